// ### src/pwm_fault_map.svh
// Notes on behaviour
// - Per-input select picks ten responses, zero ignores
// - Mode 1: output off, opposite dead, hold
// - Mode 1 acts in own phases, resumes opposite
// - Mode 2: run opposite cycle, then wait
// - Modes 2,3 act only in own phases
// - Mode 3: repeat opposite cycle while active
// - Mode 4: both outputs off, timing unchanged
// - Mode 5: both off, dead times alternate
// - Mode 6: like mode 5, counter held
// - Mode 7: halt until restart, rehalt if high
// - Restart after mode 7 begins at dead A
// - Mode 8: edge during on, jump opposite dead
// - Mode 9: edge blanks rest of on time
// - Mode 10: off while active, finish on time
// - Input ignored unless its enable bit set
// - Phases: dead A, on A, dead B, on B
`ifndef PWM_FAULT_MAP_SVH
`define PWM_FAULT_MAP_SVH

`define FR_NONE        4'h0
`define FR_JUMP_WAIT   4'h1
`define FR_EXEC_WAIT   4'h2
`define FR_EXEC_REPEAT 4'h3
`define FR_ALL_OFF     4'h4
`define FR_ALL_DEAD    4'h5
`define FR_ALL_JUMP    4'h6
`define FR_ALL_HALT    4'h7
`define FR_EDGE_JUMP   4'h8
`define FR_EDGE_BLANK  4'h9
`define FR_LEVEL_OFF   4'hA
`define FR_LAST        4'hA

`define SIDE_A         1'b0
`define SIDE_B         1'b1
`define CNT_W_DEFAULT  12

`endif

// ### src/pwm_fault_pkg.sv
package pwm_fault_pkg;

   typedef enum logic [1:0] {
      DEAD_PHASE_A,
      ON_PHASE_A,
      DEAD_PHASE_B,
      ON_PHASE_B
   } phase_t;

   typedef logic [3:0] fault_response_t;

   function automatic phase_t next_phase(input phase_t p);
      unique case (p)
         DEAD_PHASE_A: next_phase = ON_PHASE_A;
         ON_PHASE_A:   next_phase = DEAD_PHASE_B;
         DEAD_PHASE_B: next_phase = ON_PHASE_B;
         ON_PHASE_B:   next_phase = DEAD_PHASE_A;
      endcase
   endfunction

   function automatic phase_t dead_of(input logic side);
      dead_of = side ? DEAD_PHASE_B : DEAD_PHASE_A;
   endfunction

   function automatic phase_t on_of(input logic side);
      on_of = side ? ON_PHASE_B : ON_PHASE_A;
   endfunction

   function automatic logic is_on(input phase_t p);
      is_on = (p == ON_PHASE_A) || (p == ON_PHASE_B);
   endfunction

endpackage

// ### src/fault_input_ctrl.sv
`timescale 1ns/1ps
`include "pwm_fault_map.svh"

module fault_input_ctrl
   import pwm_fault_pkg::*;
(
   // Clock and reset
   input  wire logic            i_sys_clk,
   input  wire logic            i_srst,
   // Event input and its control
   input  wire logic            i_fault,
   input  wire logic            i_fault_input_enable,
   input  wire fault_response_t i_fault_response_select,
   // Qualified event
   output logic                 o_active,
   output logic                 o_rise,
   output fault_response_t      o_mode
);

   logic prev_reg;
   logic prev_next;

   always_comb begin
      prev_next = o_active;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
      end
   end

   assign o_active = i_fault & i_fault_input_enable;
   assign o_rise   = o_active & ~prev_reg;
   // Reserved codes decode to no response
   assign o_mode   = (i_fault_response_select > `FR_LAST) ? `FR_NONE
                     : i_fault_response_select;

endmodule // fault_input_ctrl

// ### src/pwm_fault_input_modes.sv
`timescale 1ns/1ps
`include "pwm_fault_map.svh"

module pwm_fault_input_modes
   import pwm_fault_pkg::*;
#(
   parameter int CNT_W = `CNT_W_DEFAULT
) (
   // Clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_srst,
   // Timer control
   input  wire logic             i_run,
   input  wire logic             i_restart,
   input  wire logic [CNT_W-1:0] i_len_dead_a,
   input  wire logic [CNT_W-1:0] i_len_on_a,
   input  wire logic [CNT_W-1:0] i_len_dead_b,
   input  wire logic [CNT_W-1:0] i_len_on_b,
   // Event inputs A and B
   input  wire logic             i_fault_a,
   input  wire logic             i_fault_b,
   input  wire logic             i_fault_input_enable_a,
   input  wire logic             i_fault_input_enable_b,
   input  wire fault_response_t  i_fault_response_select_a,
   input  wire fault_response_t  i_fault_response_select_b,
   // Waveforms and status
   output logic                  o_waveform_out_a,
   output logic                  o_waveform_out_b,
   output phase_t                o_phase,
   output logic [CNT_W-1:0]      o_count,
   output logic                  o_halted
);

   logic            act  [2];
   logic            rise [2];
   fault_response_t mode [2];

   fault_input_ctrl u_in_a (
      .i_sys_clk               (i_sys_clk),
      .i_srst                  (i_srst),
      .i_fault                 (i_fault_a),
      .i_fault_input_enable    (i_fault_input_enable_a),
      .i_fault_response_select (i_fault_response_select_a),
      .o_active                (act[0]),
      .o_rise                  (rise[0]),
      .o_mode                  (mode[0])
   );

   fault_input_ctrl u_in_b (
      .i_sys_clk               (i_sys_clk),
      .i_srst                  (i_srst),
      .i_fault                 (i_fault_b),
      .i_fault_input_enable    (i_fault_input_enable_b),
      .i_fault_response_select (i_fault_response_select_b),
      .o_active                (act[1]),
      .o_rise                  (rise[1]),
      .o_mode                  (mode[1])
   );

   phase_t           phase_reg, phase_next;
   logic [CNT_W-1:0] count_reg, count_next;
   logic             halt_reg,  halt_next;
   logic [1:0]       pend_reg,  pend_next;
   logic [1:0]       blk_reg,   blk_next;
   logic [1:0]       wo_reg,    wo_next;
   logic [CNT_W-1:0] cur_len;
   logic             end_ph;
   logic             g_off, g_dead, g_jump, g_halt;
   logic [1:0]       kill;

   always_comb begin
      unique case (phase_reg)
         DEAD_PHASE_A: cur_len = i_len_dead_a;
         ON_PHASE_A:   cur_len = i_len_on_a;
         DEAD_PHASE_B: cur_len = i_len_dead_b;
         ON_PHASE_B:   cur_len = i_len_on_b;
      endcase
   end

   assign end_ph = (count_reg >= cur_len);

   always_comb begin
      logic   s;
      logic   own;
      phase_t opp_dead;
      s        = `SIDE_A;
      own      = 1'b0;
      opp_dead = DEAD_PHASE_A;
      g_off  = 1'b0;
      g_dead = 1'b0;
      g_jump = 1'b0;
      g_halt = 1'b0;
      kill   = 2'b00;
      pend_next = pend_reg;
      blk_next  = blk_reg;
      halt_next = halt_reg;
      // Normal flow
      if (end_ph) begin
         phase_next = next_phase(phase_reg);
         count_next = '0;
      end else begin
         phase_next = phase_reg;
         count_next = CNT_W'(count_reg + 1'b1);
      end
      for (int i = 0; i < 2; i++) begin
         s        = (i == 1) ? `SIDE_B : `SIDE_A;
         own      = (phase_reg == dead_of(s)) || (phase_reg == on_of(s));
         opp_dead = dead_of(~s);
         g_off  = g_off  | (act[i] & (mode[i] == `FR_ALL_OFF));
         g_dead = g_dead | (act[i] & (mode[i] == `FR_ALL_DEAD));
         g_jump = g_jump | (act[i] & (mode[i] == `FR_ALL_JUMP));
         g_halt = g_halt | (act[i] & (mode[i] == `FR_ALL_HALT));
         unique case (mode[i])
            `FR_JUMP_WAIT: begin
               if (act[i] && own) begin
                  phase_next = opp_dead;
                  count_next = '0;
               end else if (act[i] && phase_reg == opp_dead
                            && count_reg == '0) begin
                  count_next = '0;
               end
            end
            `FR_EXEC_WAIT, `FR_EXEC_REPEAT: begin
               if (act[i] && own) begin
                  phase_next   = opp_dead;
                  count_next   = '0;
                  pend_next[i] = 1'b1;
               end else if (pend_reg[i] && phase_reg == on_of(~s)
                            && end_ph) begin
                  if (act[i] && mode[i] == `FR_EXEC_WAIT) begin
                     phase_next = phase_reg;
                     count_next = count_reg;
                  end else if (act[i]) begin
                     phase_next = opp_dead;
                  end else begin
                     pend_next[i] = 1'b0;
                  end
               end
            end
            `FR_EDGE_JUMP: begin
               if (rise[i] && phase_reg == on_of(s)) begin
                  phase_next = opp_dead;
                  count_next = '0;
               end
            end
            `FR_EDGE_BLANK: begin
               if (rise[i] && phase_reg == on_of(s)) begin
                  blk_next[i] = 1'b1;
               end
            end
            `FR_LEVEL_OFF: begin
               if (act[i]) begin
                  blk_next[i] = 1'b1;
               end
            end
            default: begin
            end
         endcase
         if (mode[i] != `FR_EXEC_WAIT && mode[i] != `FR_EXEC_REPEAT) begin
            pend_next[i] = 1'b0;
         end
         // Blanking ends with the own on time
         if (blk_reg[i] && (phase_reg != on_of(s) || end_ph)
             && !(act[i] && mode[i] == `FR_LEVEL_OFF)) begin
            blk_next[i] = 1'b0;
         end
         // Blanking also covers the last slot of the on time
         kill[i] = blk_reg[i] | blk_next[i]
                   | (rise[i] & (mode[i] == `FR_EDGE_JUMP))
                   | (act[i] & (mode[i] == `FR_JUMP_WAIT
                   || mode[i] == `FR_EXEC_WAIT
                   || mode[i] == `FR_EXEC_REPEAT));
      end
      // Shared responses
      if (g_dead || g_jump) begin
         if (is_on(phase_reg)) begin
            phase_next = next_phase(phase_reg);
            count_next = '0;
         end else if (end_ph) begin
            phase_next = next_phase(next_phase(phase_reg));
         end else if (g_jump && count_reg == '0) begin
            count_next = '0;
         end
      end
      if (halt_reg) begin
         phase_next = phase_reg;
         count_next = count_reg;
         if (i_restart) begin
            halt_next  = 1'b0;
            phase_next = DEAD_PHASE_A;
            count_next = '0;
         end
      end
      if (g_halt) begin
         halt_next = 1'b1;
      end
      wo_next[0] = (phase_reg == ON_PHASE_A) & ~kill[0];
      wo_next[1] = (phase_reg == ON_PHASE_B) & ~kill[1];
      if (g_off || g_dead || g_jump || g_halt || halt_reg) begin
         wo_next = 2'b00;
      end
      if (!i_run) begin
         phase_next = DEAD_PHASE_A;
         count_next = '0;
         halt_next  = 1'b0;
         pend_next  = 2'b00;
         blk_next   = 2'b00;
         wo_next    = 2'b00;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         phase_reg <= DEAD_PHASE_A;
         count_reg <= '0;
         halt_reg  <= 1'b0;
         pend_reg  <= 2'b00;
         blk_reg   <= 2'b00;
         wo_reg    <= 2'b00;
      end else begin
         phase_reg <= phase_next;
         count_reg <= count_next;
         halt_reg  <= halt_next;
         pend_reg  <= pend_next;
         blk_reg   <= blk_next;
         wo_reg    <= wo_next;
      end
   end

   assign o_waveform_out_a = wo_reg[0];
   assign o_waveform_out_b = wo_reg[1];
   assign o_phase          = phase_reg;
   assign o_count          = count_reg;
   assign o_halted         = halt_reg;

   halt_set_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (i_run && g_halt) |=> (o_halted && !o_waveform_out_a
                             && !o_waveform_out_b))
      else $error("halt response did not stop the timer");

   restart_dta_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (i_run && halt_reg && i_restart) |=> (o_phase == DEAD_PHASE_A
                                            && o_count == '0))
      else $error("restart did not begin at dead phase A");

   all_off_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      g_off |=> (!o_waveform_out_a && !o_waveform_out_b))
      else $error("outputs active during all-off response");

   seq_order_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (i_run && !halt_reg && end_ph && !act[0] && !act[1]
       && pend_reg == 2'b00)
      |=> (o_phase == next_phase($past(phase_reg))))
      else $error("phase sequence broken");

   jump_wait_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (i_run && !halt_reg && mode[0] == `FR_JUMP_WAIT && act[0]
       && !act[1]
       && (phase_reg == DEAD_PHASE_A || phase_reg == ON_PHASE_A))
      |=> (o_phase == DEAD_PHASE_B && o_count == '0) ##1
          (!act[0] || o_count == '0))
      else $error("jump-and-wait response wrong");

   edge_blank_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (mode[0] == `FR_EDGE_BLANK && rise[0] && phase_reg == ON_PHASE_A)
      |=> !o_waveform_out_a)
      else $error("edge did not blank output A");

   level_off_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (mode[1] == `FR_LEVEL_OFF && act[1]) |=> !o_waveform_out_b)
      else $error("output B on during active level");

   reserved_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (i_fault_response_select_a > `FR_LAST) |-> (mode[0] == `FR_NONE))
      else $error("reserved code not treated as none");

   disabled_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (!i_fault_input_enable_b) |-> (!act[1] && !rise[1]))
      else $error("disabled input took effect");

endmodule // pwm_fault_input_modes

// ### dv/event_route_model.sv
`timescale 1ns/1ps

module event_route_model (
   // Clock
   input  wire logic i_sys_clk,
   // Requests from the bench
   input  wire logic i_req_a,
   input  wire logic i_req_b,
   // Event lines to the block
   output logic      o_fault_a,
   output logic      o_fault_b
);
   // Routing adds one clock of latency
   always_ff @(posedge i_sys_clk) begin
      o_fault_a <= i_req_a;
      o_fault_b <= i_req_b;
   end
endmodule // event_route_model

// ### dv/testbench.sv
`timescale 1ns/1ps

module testbench;
   import pwm_fault_pkg::*;
   localparam int CW = 12;
   localparam int LD = 3;
   localparam int LO = 7;
   logic            clk, srst, run, restart, req_a, req_b, en_a, en_b;
   logic            fa, fb, out_a, out_b, halted;
   fault_response_t sel_a, sel_b;
   phase_t          phase;
   logic [CW-1:0]   count;
   int              err_total, tests_run, cycles;

   event_route_model event_route_model_i (.i_sys_clk(clk), .i_req_a(req_a),
      .i_req_b(req_b), .o_fault_a(fa), .o_fault_b(fb));

   pwm_fault_input_modes #(.CNT_W(CW)) pwm_fault_input_modes_i (
      .i_sys_clk(clk), .i_srst(srst), .i_run(run), .i_restart(restart),
      .i_len_dead_a(CW'(LD)), .i_len_on_a(CW'(LO)),
      .i_len_dead_b(CW'(LD)), .i_len_on_b(CW'(LO)),
      .i_fault_a(fa), .i_fault_b(fb),
      .i_fault_input_enable_a(en_a), .i_fault_input_enable_b(en_b),
      .i_fault_response_select_a(sel_a), .i_fault_response_select_b(sel_b),
      .o_waveform_out_a(out_a), .o_waveform_out_b(out_b),
      .o_phase(phase), .o_count(count), .o_halted(halted));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic print_verdict;
      $display("err_total=%0d tests_run=%0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         print_verdict();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wait_phase(input phase_t p, output logic ok);
      ok = 1'b0;
      for (int k = 0; k < 100 && !ok; k++) begin
         step(1);
         ok = (phase === p);
      end
   endtask

   task automatic drive_fault(input logic a, input logic b);
      @(posedge clk);
      req_a <= a;
      req_b <= b;
   endtask

   // Clean sequencer start with chosen codes and enables
   task automatic start_seq(input fault_response_t sa, input fault_response_t sb,
                            input logic ea, input logic eb);
      @(posedge clk);
      run <= 1'b0; sel_a <= sa; sel_b <= sb; en_a <= ea; en_b <= eb;
      req_a <= 1'b0; req_b <= 1'b0; restart <= 1'b0;
      repeat (2) @(posedge clk);
      run <= 1'b1;
   endtask

   task automatic pulse_restart;
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      #1;
   endtask

   task automatic t_sequence;
      logic ok;
      int   n;
      start_seq(4'h0, 4'h0, 1'b0, 1'b0);
      wait_phase(ON_PHASE_A, ok);
      n = 0;
      do begin
         step(1);
         n++;
      end while (phase === ON_PHASE_A && n < 50);
      check(n, LO + 1);
      check(phase, DEAD_PHASE_B);
      wait_phase(ON_PHASE_B, ok);
      step(2);
      check({out_a, out_b}, 2'b01);
      wait_phase(DEAD_PHASE_A, ok);
      check(ok, 1'b1);
   endtask

   task automatic t_mode4;
      logic ok;
      int   hits;
      start_seq(4'h4, 4'h4, 1'b1, 1'b1);
      drive_fault(1'b0, 1'b1);
      step(3);
      hits = 0;
      repeat (40) begin
         step(1);
         hits += int'(out_a === 1'b1 || out_b === 1'b1);
      end
      check(hits, 0);
      check(phase, ON_PHASE_B);
      wait_phase(ON_PHASE_B, ok);
      check(ok, 1'b1);
      drive_fault(1'b0, 1'b0);
      wait_phase(ON_PHASE_A, ok);
      step(2);
      check(out_a, 1'b1);
   endtask

   task automatic t_ignored;
      logic ok;
      start_seq(4'hB, 4'h4, 1'b1, 1'b0);
      drive_fault(1'b1, 1'b1);
      wait_phase(ON_PHASE_A, ok);
      step(2);
      check(out_a, 1'b1);
      wait_phase(ON_PHASE_B, ok);
      step(2);
      check(out_b, 1'b1);
      drive_fault(1'b0, 1'b0);
   endtask

   task automatic t_mode1;
      logic ok;
      start_seq(4'h1, 4'h1, 1'b1, 1'b1);
      wait_phase(ON_PHASE_A, ok);
      drive_fault(1'b1, 1'b0);
      step(8);
      check(phase, DEAD_PHASE_B);
      check(count, '0);
      check(out_a, 1'b0);
      drive_fault(1'b0, 1'b0);
      wait_phase(ON_PHASE_B, ok);
      check(ok, 1'b1);
   endtask

   task automatic t_mode2;
      logic ok;
      start_seq(4'h2, 4'h0, 1'b1, 1'b1);
      wait_phase(ON_PHASE_A, ok);
      drive_fault(1'b1, 1'b0);
      step(17);
      check(phase, ON_PHASE_B);
      check(count, LO);
      check(out_a, 1'b0);
      drive_fault(1'b0, 1'b0);
      step(2);
      check(phase, DEAD_PHASE_A);
      check(count, '0);
   endtask

   task automatic t_mode3;
      logic ok;
      start_seq(4'h0, 4'h3, 1'b1, 1'b1);
      wait_phase(ON_PHASE_B, ok);
      drive_fault(1'b0, 1'b1);
      step(14);
      check(phase, DEAD_PHASE_A);
      check(count, '0);
      drive_fault(1'b0, 1'b0);
      wait_phase(ON_PHASE_A, ok);
      check(ok, 1'b1);
      wait_phase(DEAD_PHASE_B, ok);
      check(ok, 1'b1);
   endtask

   task automatic t_mode5;
      logic ok;
      start_seq(4'h5, 4'h0, 1'b1, 1'b1);
      wait_phase(ON_PHASE_A, ok);
      drive_fault(1'b1, 1'b0);
      step(8);
      check(phase, DEAD_PHASE_A);
      check({out_a, out_b}, 2'b00);
      drive_fault(1'b0, 1'b0);
      wait_phase(ON_PHASE_B, ok);
      check(ok, 1'b1);
      step(2);
      check(out_b, 1'b1);
   endtask

   task automatic t_mode6;
      logic ok;
      start_seq(4'h0, 4'h6, 1'b1, 1'b1);
      wait_phase(ON_PHASE_A, ok);
      drive_fault(1'b0, 1'b1);
      step(8);
      check(phase, DEAD_PHASE_B);
      check(count, '0);
      check({out_a, out_b}, 2'b00);
      drive_fault(1'b0, 1'b0);
      wait_phase(ON_PHASE_B, ok);
      check(ok, 1'b1);
   endtask

   task automatic t_mode10;
      logic ok;
      int   hits;
      start_seq(4'h0, 4'hA, 1'b1, 1'b1);
      wait_phase(ON_PHASE_B, ok);
      drive_fault(1'b0, 1'b1);
      step(2);
      check(out_b, 1'b0);
      drive_fault(1'b0, 1'b0);
      hits = 0;
      repeat (5) begin
         step(1);
         hits += int'(out_b === 1'b1);
      end
      check(hits, 0);
      wait_phase(ON_PHASE_B, ok);
      step(2);
      check(out_b, 1'b1);
   endtask

   task automatic t_mode8;
      logic ok;
      start_seq(4'h8, 4'h8, 1'b1, 1'b1);
      wait_phase(ON_PHASE_B, ok);
      drive_fault(1'b0, 1'b1);
      drive_fault(1'b0, 1'b0);
      step(1);
      check(phase, DEAD_PHASE_A);
      check(count, '0);
      check(out_b, 1'b0);
   endtask

   task automatic t_mode9;
      logic ok;
      int   n, hits;
      start_seq(4'h9, 4'h9, 1'b1, 1'b1);
      wait_phase(ON_PHASE_A, ok);
      drive_fault(1'b1, 1'b0);
      drive_fault(1'b0, 1'b0);
      step(2);
      n = 0;
      hits = 0;
      while (phase === ON_PHASE_A && n < 20) begin
         hits += int'(out_a === 1'b1);
         step(1);
         n++;
      end
      check(hits, 0);
      check(n, LO - 3);
      check(out_a, 1'b0);
      wait_phase(ON_PHASE_A, ok);
      step(2);
      check(out_a, 1'b1);
   endtask

   task automatic t_mode7;
      logic          ok;
      logic [CW-1:0] held;
      start_seq(4'h7, 4'h7, 1'b1, 1'b1);
      wait_phase(ON_PHASE_B, ok);
      drive_fault(1'b1, 1'b0);
      step(3);
      check({halted, out_a, out_b}, 3'b100);
      held = count;
      step(4);
      check(count, held);
      pulse_restart();
      step(2);
      check(halted, 1'b1);
      drive_fault(1'b0, 1'b0);
      pulse_restart();
      check(halted, 1'b0);
      check(phase, DEAD_PHASE_A);
      check(count, '0);
   endtask

   initial begin
      srst = 1'b1; run = 1'b0; restart = 1'b0; req_a = 1'b0; req_b = 1'b0;
      en_a = 1'b0; en_b = 1'b0; sel_a = 4'h0; sel_b = 4'h0;
      err_total = 0; tests_run = 0; cycles = 0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_sequence();
      t_mode4();
      t_ignored();
      t_mode1();
      t_mode8();
      t_mode9();
      t_mode2();
      t_mode3();
      t_mode5();
      t_mode6();
      t_mode10();
      t_mode7();
      print_verdict();
   end
endmodule // testbench
